//--- logic/char_lcd_instruction_decoder.sv
// Instruction decoder, address pointer and memories of a character display controller
// How it works
// - Two host registers: command and data
// - While busy only status reads execute
// - Pointer steps by one after access
// - Clear fills spaces, pointer zero, increment
// - Home zeroes pointer and display shift
// - Entry mode stores direction and shift
// - Text writes shift display when enabled
// - Display control stores visible, cursor, blink
// - Cursor row depends on font height
// - Blink toggles every 409.6 ms
// - Shift instruction moves cursor or display
// - Display shift keeps pointer, lines rotate
// - Cursor wraps from line one onward
// - Function set picks bus width
// - Function set stores lines and font
// - Glyph address loads pointer, selects glyphs
// - Text address loads pointer, selects text
// - Status read gives busy and pointer
// - Data access uses selected memory
// - Execution times per instruction
// - Text address ranges per line mode
// - Four-bit mode sends two nibbles
//
// The address map and the AXI4-Lite slave port were left to the implementer.
module char_lcd_instruction_decoder
    import lcd_ctrl_pkg::*;
#(
    parameter int unsigned T_SHORT = CYC_SHORT,
    parameter int unsigned T_CLEAR = CYC_CLEAR,
    parameter int unsigned T_HOME  = CYC_HOME,
    parameter int unsigned T_BLINK = CYC_BLINK
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Display state for the drive logic
    output logic [5:0]       display_offset,
    output logic [6:0]       cursor_addr,
    output logic             cursor_visible,
    output logic [3:0]       cursor_row,
    output logic             cursor_blink_phase,
    output logic             display_visible
);
    import lcd_ctrl_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CLEAR = 2'b01,
        ST_BUSY  = 2'b10
    } exec_state_t;

    exec_state_t       state_reg;
    logic [CNT_W-1:0]  busy_cnt_reg;
    logic [CNT_W-1:0]  blink_cnt_reg;
    logic [6:0]        clr_idx_reg;
    logic [6:0]        address_pointer_reg;
    logic              glyph_sel_reg;
    logic              step_direction_reg;
    logic              shift_with_entry_reg;
    logic              display_visible_reg;
    logic              cursor_visible_reg;
    logic              cursor_blink_reg;
    logic              bus_width_select_reg;
    logic              line_count_select_reg;
    logic              font_height_select_reg;
    logic [5:0]        shift_reg;
    logic              blink_phase_reg;
    logic              nib_low_reg;
    logic [3:0]        nib_hi_reg;
    logic              pend_step_reg;
    logic [7:0]        read_latch_reg;
    logic [7:0]        text_mem [0:127];
    logic [7:0]        glyph_mem [0:63];

    logic busy_indicator;
    assign busy_indicator = (state_reg != ST_IDLE);

    // Bus slave: write path takes address and data in any order
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    // Strobe kept with the data: the master may drop it once W is taken
    logic        w_strb0_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    logic wr_fire;
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb0_reg <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (aw_addr_reg == A_CMD || aw_addr_reg == A_DATA ||
                                aw_addr_reg == A_CONFIG || aw_addr_reg == A_STATUS) ? RESP_OKAY : RESP_SLV;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Nibble assembly: upper nibble first in 4-bit mode
    logic       wr_cmd;
    logic       wr_dat;
    logic       byte_done;
    logic [7:0] wr_byte;
    assign wr_cmd    = wr_fire && aw_addr_reg == A_CMD && w_strb0_reg;
    assign wr_dat    = wr_fire && aw_addr_reg == A_DATA && w_strb0_reg;
    assign byte_done = bus_width_select_reg || nib_low_reg;
    assign wr_byte   = bus_width_select_reg ? w_data_reg[7:0] : {nib_hi_reg, w_data_reg[7:4]};

    // Read path; a data read is a bus access too, so it also pairs nibbles
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        rd_dat;
    logic        rd_nib_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign rd_dat = s_axi_arvalid && !rvalid_reg && s_axi_araddr == A_DATA && !busy_indicator
                    && (bus_width_select_reg || !rd_nib_reg);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= RESP_OKAY;
            rd_nib_reg <= 1'b0;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            case (s_axi_araddr)
                A_CMD: begin
                    rdata_reg <= {24'h000000, busy_indicator, address_pointer_reg};
                end
                A_DATA: begin
                    if (!bus_width_select_reg && rd_nib_reg) begin
                        rdata_reg  <= {24'h000000, read_latch_reg[3:0], 4'h0};
                        rd_nib_reg <= 1'b0;
                    end else if (!busy_indicator) begin
                        rdata_reg  <= {24'h000000, rd_byte(glyph_sel_reg, address_pointer_reg)};
                        rd_nib_reg <= !bus_width_select_reg;
                    end else begin
                        rdata_reg <= 32'h00000000;
                    end
                end
                A_STATUS: begin
                    rdata_reg <= {22'h000000, bus_width_select_reg, line_count_select_reg,
                                  font_height_select_reg, display_visible_reg, cursor_visible_reg,
                                  cursor_blink_reg, step_direction_reg, shift_with_entry_reg,
                                  glyph_sel_reg, busy_indicator};
                end
                A_CONFIG: begin
                    rdata_reg <= {26'h0000000, shift_reg};
                end
                default: begin
                    rdata_reg <= 32'h00000000;
                    rresp_reg <= RESP_SLV;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rd_dat) begin
            read_latch_reg <= rd_byte(glyph_sel_reg, address_pointer_reg);
        end
    end

    function automatic logic [7:0] rd_byte(input logic gsel, input logic [6:0] a);
        rd_byte = gsel ? glyph_mem[a[5:0]] : text_mem[a];
    endfunction : rd_byte

    // Pointer step within the text ranges of the line mode
    function automatic logic [6:0] step_ptr(input logic [6:0] a, input logic up, input logic gsel,
                                            input logic two_line);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (gsel) begin
            r = {1'b0, r[5:0]};
        end else if (two_line) begin
            if (up && a == LINE1_LAST) r = LINE2_FIRST;
            else if (up && a == LINE2_LAST) r = 7'h00;
            else if (!up && a == 7'h00) r = LINE2_LAST;
            else if (!up && a == LINE2_FIRST) r = LINE1_LAST;
        end else begin
            if (up && a == ONE_LINE_LAST) r = 7'h00;
            else if (!up && a == 7'h00) r = ONE_LINE_LAST;
        end
        step_ptr = r;
    endfunction : step_ptr

    function automatic logic [5:0] rot(input logic [5:0] s, input logic left);
        if (left) rot = (s == LINE_LEN - 6'h01) ? 6'h00 : s + 6'h01;
        else rot = (s == 6'h00) ? LINE_LEN - 6'h01 : s - 6'h01;
    endfunction : rot

    logic accept;
    assign accept = (wr_cmd || wr_dat) && byte_done && !busy_indicator;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nib_low_reg <= 1'b0;
            nib_hi_reg  <= 4'h0;
        end else if ((wr_cmd || wr_dat) && !bus_width_select_reg) begin
            nib_low_reg <= !nib_low_reg;
            nib_hi_reg  <= w_data_reg[7:4];
        end
    end

    // Instruction execution and busy timing
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg              <= ST_IDLE;
            busy_cnt_reg           <= '0;
            clr_idx_reg            <= 7'h00;
            address_pointer_reg    <= 7'h00;
            glyph_sel_reg          <= 1'b0;
            step_direction_reg     <= 1'b1;
            shift_with_entry_reg   <= 1'b0;
            display_visible_reg    <= 1'b0;
            cursor_visible_reg     <= 1'b0;
            cursor_blink_reg       <= 1'b0;
            bus_width_select_reg   <= 1'b1;
            line_count_select_reg  <= 1'b0;
            font_height_select_reg <= 1'b0;
            shift_reg              <= 6'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept && wr_dat) begin
                        busy_cnt_reg <= CNT_W'(T_SHORT);
                        state_reg    <= ST_BUSY;
                        if (!glyph_sel_reg && shift_with_entry_reg)
                            shift_reg <= rot(shift_reg, step_direction_reg);
                    end else if (rd_dat) begin
                        busy_cnt_reg <= CNT_W'(T_SHORT);
                        state_reg    <= ST_BUSY;
                    end else if (accept) begin
                        busy_cnt_reg <= CNT_W'(T_SHORT);
                        state_reg    <= ST_BUSY;
                        if (wr_byte[B_TXT]) begin
                            address_pointer_reg <= wr_byte[6:0];
                            glyph_sel_reg       <= 1'b0;
                        end else if (wr_byte[B_GLY]) begin
                            address_pointer_reg <= {1'b0, wr_byte[5:0]};
                            glyph_sel_reg       <= 1'b1;
                        end else if (wr_byte[B_FUNC]) begin
                            bus_width_select_reg   <= wr_byte[4];
                            line_count_select_reg  <= wr_byte[3];
                            font_height_select_reg <= wr_byte[2];
                        end else if (wr_byte[B_SHFT]) begin
                            if (wr_byte[3])
                                shift_reg <= rot(shift_reg, !wr_byte[2]);
                            else
                                address_pointer_reg <= step_ptr(address_pointer_reg, wr_byte[2],
                                                                glyph_sel_reg, line_count_select_reg);
                        end else if (wr_byte[B_DISP]) begin
                            display_visible_reg <= wr_byte[2];
                            cursor_visible_reg  <= wr_byte[1];
                            cursor_blink_reg    <= wr_byte[0];
                        end else if (wr_byte[B_ENT]) begin
                            step_direction_reg   <= wr_byte[1];
                            shift_with_entry_reg <= wr_byte[0];
                        end else if (wr_byte[B_HOME]) begin
                            address_pointer_reg <= 7'h00;
                            shift_reg           <= 6'h00;
                            glyph_sel_reg       <= 1'b0;
                            busy_cnt_reg        <= CNT_W'(T_HOME);
                        end else if (wr_byte[B_CLR]) begin
                            address_pointer_reg <= 7'h00;
                            shift_reg           <= 6'h00;
                            glyph_sel_reg       <= 1'b0;
                            step_direction_reg  <= 1'b1;
                            clr_idx_reg         <= 7'h00;
                            busy_cnt_reg        <= CNT_W'(T_CLEAR);
                            state_reg           <= ST_CLEAR;
                        end
                    end
                end
                ST_CLEAR: begin
                    clr_idx_reg  <= clr_idx_reg + 7'h01;
                    busy_cnt_reg <= busy_cnt_reg - CNT_W'(1);
                    if (clr_idx_reg == 7'h7F) state_reg <= ST_BUSY;
                end
                ST_BUSY: begin
                    busy_cnt_reg <= busy_cnt_reg - CNT_W'(1);
                    if (busy_cnt_reg <= CNT_W'(1)) begin
                        state_reg <= ST_IDLE;
                        if (pend_step_reg)
                            address_pointer_reg <= step_ptr(address_pointer_reg, step_direction_reg,
                                                            glyph_sel_reg, line_count_select_reg);
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // A data access steps the pointer as busy falls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) pend_step_reg <= 1'b0;
        else if (state_reg == ST_IDLE) pend_step_reg <= (accept && wr_dat) || rd_dat;
    end

    // Memories carry no reset so they map onto RAM
    always_ff @(posedge sys_clk) begin
        if (state_reg == ST_CLEAR) text_mem[clr_idx_reg] <= SPACE_CODE;
        else if (state_reg == ST_IDLE && accept && wr_dat) begin
            if (glyph_sel_reg) glyph_mem[address_pointer_reg[5:0]] <= wr_byte;
            else text_mem[address_pointer_reg] <= wr_byte;
        end
    end

    // Blink timebase; its count is set in system clock periods
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt_reg   <= '0;
            blink_phase_reg <= 1'b0;
        end else if (blink_cnt_reg >= CNT_W'(T_BLINK - 1)) begin
            blink_cnt_reg   <= '0;
            blink_phase_reg <= !blink_phase_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + CNT_W'(1);
        end
    end

    assign display_offset     = shift_reg;
    assign cursor_addr        = address_pointer_reg;
    assign cursor_visible     = cursor_visible_reg;
    assign cursor_row         = font_height_select_reg ? 4'hA : 4'h7;
    assign cursor_blink_phase = cursor_blink_reg & blink_phase_reg;
    assign display_visible    = display_visible_reg;

    property p_busy_blocks;
        @(posedge sys_clk) disable iff (!nrst)
        (busy_indicator && wr_cmd) |=> $stable(display_visible_reg) && $stable(step_direction_reg);
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("command executed while busy");

    property p_clear_ptr;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && !wr_dat && wr_byte == 8'h01) |=> address_pointer_reg == 7'h00 && step_direction_reg
                                                    && state_reg == ST_CLEAR;
    endproperty
    a_clear_ptr: assert property (p_clear_ptr) else $error("clear did not reset pointer");

    property p_busy_after;
        @(posedge sys_clk) disable iff (!nrst)
        (state_reg == ST_IDLE && accept) |=> busy_indicator;
    endproperty
    a_busy_after: assert property (p_busy_after) else $error("busy not raised");

    property p_text_addr;
        @(posedge sys_clk) disable iff (!nrst)
        (accept && !wr_dat && wr_byte[B_TXT]) |=> !glyph_sel_reg && address_pointer_reg == $past(wr_byte[6:0]);
    endproperty
    a_text_addr: assert property (p_text_addr) else $error("text address not loaded");

    property p_blink_period;
        @(posedge sys_clk) disable iff (!nrst)
        $changed(blink_phase_reg) |=> !$changed(blink_phase_reg);
    endproperty
    a_blink_period: assert property (p_blink_period) else $error("blink toggled too fast");

    property p_step_on_fall;
        @(posedge sys_clk) disable iff (!nrst)
        ($fell(busy_indicator) && $past(pend_step_reg) && !glyph_sel_reg && line_count_select_reg
         && step_direction_reg && $past(address_pointer_reg) == LINE1_LAST) |-> address_pointer_reg == LINE2_FIRST;
    endproperty
    a_step_on_fall: assert property (p_step_on_fall) else $error("line wrap wrong");

    property p_cursor_row;
        @(posedge sys_clk) disable iff (!nrst)
        font_height_select_reg |-> cursor_row == 4'hA;
    endproperty
    a_cursor_row: assert property (p_cursor_row) else $error("cursor row wrong");

    property p_status_read;
        @(posedge sys_clk) disable iff (!nrst)
        (s_axi_arvalid && !rvalid_reg && s_axi_araddr == A_CMD) |=> s_axi_rvalid
            && s_axi_rdata[7] == $past(busy_indicator);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");
endmodule : char_lcd_instruction_decoder

//--- logic/lcd_ctrl_pkg.sv
// Constants shared by the character display instruction decoder
package lcd_ctrl_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned OSC_HZ        = 250_000;
    // Execution times in system clock periods (at 20 MHz: 40 us = 800, 1.64 ms = 32800)
    localparam int unsigned EXEC_NS_SHORT = 40_000;
    localparam int unsigned EXEC_NS_CLEAR = 1_640_000;
    localparam int unsigned EXEC_NS_HOME  = 1_600_000;
    localparam int unsigned BLINK_NS      = 409_600_000;
    localparam int unsigned CYC_SHORT     = (EXEC_NS_SHORT + 49) / 50;
    localparam int unsigned CYC_CLEAR     = (EXEC_NS_CLEAR + 49) / 50;
    localparam int unsigned CYC_HOME      = (EXEC_NS_HOME + 49) / 50;
    localparam int unsigned CYC_BLINK     = BLINK_NS / 50;
    localparam int unsigned CNT_W         = 24;
    // Instruction bit positions
    localparam int unsigned B_CLR  = 0;
    localparam int unsigned B_HOME = 1;
    localparam int unsigned B_ENT  = 2;
    localparam int unsigned B_DISP = 3;
    localparam int unsigned B_SHFT = 4;
    localparam int unsigned B_FUNC = 5;
    localparam int unsigned B_GLY  = 6;
    localparam int unsigned B_TXT  = 7;
    localparam logic [7:0] SPACE_CODE    = 8'h20;
    localparam logic [6:0] LINE1_LAST    = 7'h27;
    localparam logic [6:0] LINE2_FIRST   = 7'h40;
    localparam logic [6:0] LINE2_LAST    = 7'h67;
    localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
    localparam logic [5:0] LINE_LEN      = 6'h28;
    // AXI4-Lite map (byte addresses)
    localparam logic [7:0] A_CMD     = 8'h00;
    localparam logic [7:0] A_DATA    = 8'h04;
    localparam logic [7:0] A_STATUS  = 8'h08;
    localparam logic [7:0] A_CONFIG  = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLV  = 2'h2;
endpackage : lcd_ctrl_pkg

//--- tb/host_bus.sv
// Host bus master model: register accesses and busy polling
module host_bus (
    input  wire logic        sys_clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input  wire logic [31:0] s_axi_rdata,
    output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    output logic [7:0]       s_axi_awaddr, s_axi_araddr,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] d;
    logic [1:0]  r;
    // Strobe of the next write; a scenario may clear it
    logic [3:0]  strb = 4'hF;
    initial s_axi_wstrb = ~strb;
    initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    // Released payload is inverted so a stale value never looks valid
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] v);
        if (rd) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        else {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <=
            {a, 24'h0, v, strb, 3'b111};
        repeat (64) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata, s_axi_wstrb} <= {1'b0, 24'h0, ~v, ~strb};
            if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            if ((s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid)) begin
                {r, d} = s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
                {s_axi_bready, s_axi_rready} <= 2'b00;
                // One edge apart, so the next call never re-raises a ready in this step
                @(posedge sys_clk);
                return;
            end
        end
        char_lcd_instruction_decoder_tb.stop_test(1'b1);
    endtask : xfer
    task automatic idle();
        repeat (600) begin
            xfer(1'b1, 8'h00, 8'h00);
            if (d[7] === 1'b0) return;
        end
        char_lcd_instruction_decoder_tb.stop_test(1'b1);
    endtask : idle
endmodule : host_bus

//--- tb/char_lcd_instruction_decoder_tb.sv
// Self-checking bench for the character display instruction decoder
module char_lcd_instruction_decoder_tb;
    import lcd_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, nrst = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        cursor_visible, cursor_blink_phase, display_visible;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, s_axi_wdata;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb, cursor_row;
    logic [6:0]  cursor_addr;
    logic [5:0]  display_offset;
    int          fail_count = 0, n_compared = 0;
    always #25 sys_clk = ~sys_clk;
    // Short execution times keep the run small
    char_lcd_instruction_decoder #(.T_SHORT(8), .T_CLEAR(200), .T_HOME(40), .T_BLINK(64))
        char_lcd_instruction_decoder_i (.*);
    host_bus host_bus_i (.*);
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %0h want %0h", $time, got, exp);
        end
    endtask : ck
    task automatic stop_test(input logic to);
        if (to) fail_count++;
        if (to) $display("[ERR] %0t no answer from the block", $time);
        $display("mismatches %0d compares %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic put(input logic [7:0] a, input logic [7:0] v);
        host_bus_i.xfer(1'b0, a, v);
        host_bus_i.idle();
    endtask : put
    task automatic s_text();
        ck(cursor_row, 4'h7);
        put(A_CMD, 8'h85);
        put(A_DATA, 8'h41);
        ck(cursor_addr, 7'h06);
        put(A_CMD, 8'h01);
        ck(cursor_addr, 7'h00);
        put(A_CMD, 8'h85);
        host_bus_i.xfer(1'b1, A_DATA, 8'h00);
        ck(host_bus_i.d[7:0], SPACE_CODE);
        host_bus_i.idle();
    endtask : s_text
    task automatic s_busy();
        host_bus_i.xfer(1'b0, A_CMD, 8'h80);
        host_bus_i.xfer(1'b0, A_CMD, 8'h8A);
        host_bus_i.xfer(1'b1, A_CMD, 8'h00);
        ck(host_bus_i.d[7:0], 8'h80);
        host_bus_i.idle();
        ck(cursor_addr, 7'h00);
        host_bus_i.xfer(1'b0, 8'h10, 8'h00);
        ck(host_bus_i.r, RESP_SLV);
        host_bus_i.strb = 4'h0;
        put(A_CMD, 8'h8A);
        host_bus_i.strb = 4'hF;
        ck(cursor_addr, 7'h00);
    endtask : s_busy
    task automatic s_modes();
        put(A_CMD, 8'h8A);
        put(A_CMD, 8'h04);
        put(A_DATA, 8'h55);
        ck(cursor_addr, 7'h09);
        put(A_CMD, 8'h18);
        ck({display_offset, cursor_addr}, {6'h01, 7'h09});
        put(A_CMD, 8'h3C);
        ck(cursor_row, 4'hA);
        put(A_CMD, 8'h0F);
        ck({display_visible, cursor_visible}, 2'b11);
        put(A_CMD, 8'h06);
        put(A_CMD, 8'hA7);
        put(A_DATA, 8'h31);
        ck(cursor_addr, 7'h40);
        put(A_CMD, 8'h07);
        put(A_DATA, 8'h32);
        ck({display_offset, cursor_addr}, {6'h02, 7'h41});
    endtask : s_modes
    task automatic s_blink();
        int n;
        n = 0;
        while (cursor_blink_phase !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (cursor_blink_phase === 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (cursor_blink_phase === 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        ck(n, 64);
    endtask : s_blink
    task automatic s_nibble();
        logic [3:0] hi;
        put(A_CMD, 8'h28);
        put(A_CMD, 8'h40);
        put(A_CMD, 8'h30);
        ck(cursor_addr, 7'h03);
        put(A_DATA, 8'h90);
        put(A_DATA, 8'hC0);
        ck({display_offset, cursor_addr}, {6'h02, 7'h04});
        put(A_CMD, 8'h40);
        put(A_CMD, 8'h30);
        host_bus_i.xfer(1'b1, A_DATA, 8'h00);
        hi = host_bus_i.d[7:4];
        host_bus_i.idle();
        host_bus_i.xfer(1'b1, A_DATA, 8'h00);
        ck({hi, host_bus_i.d[7:4]}, 8'h9C);
        host_bus_i.idle();
        put(A_CMD, 8'h00);
        put(A_CMD, 8'h20);
        ck({display_offset, cursor_addr}, {6'h00, 7'h00});
    endtask : s_nibble
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        s_text();
        s_busy();
        s_modes();
        s_blink();
        s_nibble();
        stop_test(1'b0);
    end
endmodule : char_lcd_instruction_decoder_tb
